/* File: ir_receive_capture_defines.svh */
/*
 * constants for the infrared receive capture block: edge select codes,
 * reset values and timing figures.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef IR_RECEIVE_CAPTURE_DEFINES_SVH
`define IR_RECEIVE_CAPTURE_DEFINES_SVH

// edge select codes
`define EDGE_SEL_NONE     2'h0
`define EDGE_SEL_RISE     2'h1
`define EDGE_SEL_FALL     2'h2
`define EDGE_SEL_BOTH     2'h3

// counter values
`define COUNT_ZERO        16'h0000
`define COUNT_ONE         16'h0001
`define COUNT_ALL_ONES    16'hFFFF

// carrier period adds this many input clocks to high and low bytes
`define CARRIER_EXTRA     10'h002
// carrier periods of silence that mark a space in burst-count mode
`define SPACE_PERIODS     2'h2

`endif

/* File: ir_receive_capture_pkg.sv */
/*
 * types shared by the infrared receive capture block.
 * assumes ir_receive_capture_defines.svh holds the numeric constants.
 */
package ir_receive_capture_pkg;
   // receive sequencing states
   typedef enum logic [1:0] {
      RX_IDLE,        // disabled or transmit mode
      RX_ARMED,       // waiting for first qualified edge
      RX_RUN          // counting between edges
   } rx_state_t;
endpackage

/* File: ir_receive_capture.sv */
/*
 * infrared receive capture: edge qualification, input clock divider,
 * carrier period timer, 16-bit interval counter, capture and burst count.
 * assumes the receive pin is already synchronous to clk, and that all
 * control bits are plain ports held by the surrounding register logic.
 */
// Summary of operation
// - receive runs when select is 0, enable 1
// - edge field picks rising, falling or both
// - counter starts from zero at first edge
// - counter clock: carrier period or input clock
// - later edge stores pin level in data bit
// - standard mode edge copies counter to capture
// - reload bit clears counter on edge
// - counter wrap between edges sets overflow, requests interrupt
// - receive stops on transmit select or disable
// - burst-count off gives standard capture behaviour
// - standard mode capture sets receive flag
// - burst mode: capture register counts edges only
// - burst mode: two silent periods set flag
// - burst enable rising with no edge that cycle loads capture with one
// - burst mode keeps clock select and reload
// - overflow request only when interrupt enabled
// - input clock is sysclk over two^divider
// - carrier period is high+low+2 input clocks
`include "ir_receive_capture_defines.svh"

module ir_receive_capture #(
   parameter int CNT_W = 16            // interval counter width
) (
   input  wire logic               clk,                     // system clock
   input  wire logic               rst_b,                   // sync reset, low
   input  wire logic               transmit_receive_select, // 0 = receive
   input  wire logic               infrared_timer_enable,   // block enable
   input  wire logic [1:0]         receive_edge_select,     // edge choice
   input  wire logic               infrared_receive_pin,    // receive pin
   input  wire logic               counter_clock_select,    // 1 = input clk
   input  wire logic [1:0]         input_clock_divider,     // power of two
   input  wire logic [7:0]         carrier_high_byte,       // carrier high
   input  wire logic [7:0]         carrier_low_byte,        // carrier low
   input  wire logic               capture_reload_bit,      // clear on edge
   input  wire logic               burst_count_enable,      // burst mode
   input  wire logic               infrared_interrupt_enable, // ovf irq en
   input  wire logic               overflow_clear,          // sw writes 0
   input  wire logic               receive_flag_clear,      // sw writes 0
   output logic [CNT_W-1:0]        interval_counter,        // running count
   output logic [CNT_W-1:0]        modulator_time_register, // capture/count
   output logic                    captured_level_bit,      // pin level
   output logic                    counter_overflow_flag,   // sticky wrap
   output logic                    receive_interrupt_flag,  // sticky event
   output logic                    overflow_irq             // gated request
);
   import ir_receive_capture_pkg::*;

   // the counter literals and wrap test are written for 16 bits
   if (CNT_W != 16) begin : g_width_check
      $error("interval counter must be 16 bits wide");
   end

   // divider decode, used only by the input clock tick logic
   function automatic logic [7:0] div_mask(input logic [1:0] sel);
      div_mask = 8'(({7'h00, 1'b1} << sel) - 8'h01);
   endfunction

   rx_state_t        state_q, state_d;   // receive sequencer
   logic [7:0]       pre_q, pre_d;       // input clock prescaler
   logic [8:0]       car_q, car_d;       // carrier period timer
   logic [1:0]       sil_q, sil_d;       // silent carrier periods
   logic             pin_q, pin_d;       // last pin level
   logic             bce_q, bce_d;       // last burst enable
   logic [CNT_W-1:0] cnt_q, cnt_d;       // interval counter
   logic [CNT_W-1:0] mt_q, mt_d;         // modulator time register
   logic             dat_q, dat_d;       // captured level
   logic             ovf_q, ovf_d;       // overflow flag
   logic             rif_q, rif_d;       // receive flag
   logic             irq_q, irq_d;       // overflow request
   logic             active;             // receive enabled
   logic             rise, fall, qual;   // edge detection
   logic             clk_tick;           // one input clock
   logic             car_tick;           // one carrier period
   logic             cnt_tick;           // counter advance
   logic [9:0]       car_len;            // carrier period length
   logic [8:0]       car_last;           // last carrier timer count

   // combinational decode of mode, edges and ticks
   always_comb begin
      active   = infrared_timer_enable && !transmit_receive_select;
      rise     = infrared_receive_pin && !pin_q;
      fall     = !infrared_receive_pin && pin_q;
      case (receive_edge_select)
         `EDGE_SEL_RISE: qual = rise;
         `EDGE_SEL_FALL: qual = fall;
         `EDGE_SEL_BOTH: qual = rise || fall;
         default:        qual = 1'b0;
      endcase
      qual     = qual && active;
      clk_tick = (pre_q & div_mask(input_clock_divider)) == 8'h00;
      car_len  = {2'h0, carrier_high_byte} + {2'h0, carrier_low_byte}
                 + `CARRIER_EXTRA;
      // the longest period is 512 clocks, so its last count fits 9 bits
      car_last = 9'(car_len - 10'h001);
      car_tick = clk_tick && (car_q == car_last);
      // counter clock choice, in both modes
      cnt_tick = counter_clock_select ? clk_tick : car_tick;
   end

   // next-state computation for the whole receive path
   always_comb begin
      state_d = state_q;
      pre_d   = pre_q + 8'h01;
      car_d   = car_q;
      sil_d   = sil_q;
      pin_d   = infrared_receive_pin;
      bce_d   = burst_count_enable;
      cnt_d   = cnt_q;
      mt_d    = mt_q;
      dat_d   = dat_q;
      // sticky flags, hardware set beats software clear
      ovf_d   = overflow_clear ? 1'b0 : ovf_q;
      rif_d   = receive_flag_clear ? 1'b0 : rif_q;
      if (clk_tick)
         car_d = (car_q >= car_last) ? 9'h000 : car_q + 9'h001;
      if (burst_count_enable && !bce_q)
         mt_d = `COUNT_ONE;
      case (state_q)
         RX_IDLE: begin
            if (active)
               state_d = RX_ARMED;
         end
         RX_ARMED: begin
            // start from zero at first edge
            cnt_d = `COUNT_ZERO;
            car_d = 9'h000;
            sil_d = 2'h0;
            if (!active)
               state_d = RX_IDLE;
            else if (qual)
               state_d = RX_RUN;
         end
         RX_RUN: begin
            if (!active) begin
               state_d = RX_IDLE;
            end else if (qual) begin
               dat_d = rise;
               sil_d = 2'h0;
               car_d = 9'h000;
               if (burst_count_enable) begin
                  mt_d = mt_q + `COUNT_ONE;
               end else begin
                  mt_d  = cnt_q;
                  rif_d = 1'b1;
               end
               if (capture_reload_bit)
                  cnt_d = `COUNT_ZERO;
               else if (cnt_tick)
                  cnt_d = cnt_q + `COUNT_ONE;
            end else begin
               if (cnt_tick) begin
                  cnt_d = cnt_q + `COUNT_ONE;
                  if (cnt_q == `COUNT_ALL_ONES)
                     ovf_d = 1'b1;
               end
               // two silent periods mark a space
               if (car_tick && sil_q != `SPACE_PERIODS) begin
                  sil_d = sil_q + 2'h1;
                  if (burst_count_enable && sil_q == `SPACE_PERIODS - 2'h1)
                     rif_d = 1'b1;
               end
            end
         end
         default: state_d = RX_IDLE;
      endcase
      irq_d = ovf_d && infrared_interrupt_enable;
   end

   // register stage
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state_q <= RX_IDLE;
         pre_q   <= 8'h00;
         car_q   <= 9'h000;
         sil_q   <= 2'h0;
         pin_q   <= 1'b0;
         bce_q   <= 1'b0;
         cnt_q   <= `COUNT_ZERO;
         mt_q    <= `COUNT_ZERO;
         dat_q   <= 1'b0;
         ovf_q   <= 1'b0;
         rif_q   <= 1'b0;
         irq_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         pre_q   <= pre_d;
         car_q   <= car_d;
         sil_q   <= sil_d;
         pin_q   <= pin_d;
         bce_q   <= bce_d;
         cnt_q   <= cnt_d;
         mt_q    <= mt_d;
         dat_q   <= dat_d;
         ovf_q   <= ovf_d;
         rif_q   <= rif_d;
         irq_q   <= irq_d;
      end
   end

   assign interval_counter        = cnt_q;
   assign modulator_time_register = mt_q;
   assign captured_level_bit      = dat_q;
   assign counter_overflow_flag   = ovf_q;
   assign receive_interrupt_flag  = rif_q;
   assign overflow_irq            = irq_q;

   // edge in standard mode captures the count
   capture_copy_a: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == RX_RUN && active && qual && !burst_count_enable
      && !(burst_count_enable && !bce_q)
      |=> mt_q == $past(cnt_q) && rif_q)
      else $error("capture did not copy counter");

   // data bit follows edge direction
   level_store_a: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == RX_RUN && qual |=> dat_q == $past(infrared_receive_pin))
      else $error("captured level wrong");

   // reload clears the counter
   reload_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == RX_RUN && qual && capture_reload_bit |=> cnt_q == 16'h0000)
      else $error("counter not reloaded");

   // wrap raises overflow
   wrap_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
      state_q == RX_RUN && active && !qual && cnt_tick && cnt_q == 16'hFFFF
      |=> ovf_q && cnt_q == 16'h0000)
      else $error("overflow not flagged");

   // request only when enabled
   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      overflow_irq |-> counter_overflow_flag && $past(infrared_interrupt_enable))
      else $error("overflow request without enable");

   // burst enable rising loads one
   burst_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      burst_count_enable && !bce_q && !(state_q == RX_RUN && qual && active)
      |=> mt_q == 16'h0001)
      else $error("burst load missing");

   // disabled receive leaves counter still
   rx_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      !active && state_q == RX_IDLE |=> $stable(cnt_q) && $stable(dat_q))
      else $error("receive active while disabled");

   // flag holds until cleared
   flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      ovf_q && !overflow_clear |=> ovf_q)
      else $error("overflow flag dropped");

   // input clock tick spacing matches a divider setting of 1
   div_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
      clk_tick && input_clock_divider == 2'h1 && $stable(input_clock_divider)
      |=> !clk_tick)
      else $error("input clock divider wrong");

endmodule // ir_receive_capture

/* File: ir_source.sv */
/* ir_source: model of the external infrared receiver output that
   drives the receive pin of the capture block.
   assumes the bench calls flip() at a rising edge of clk. */
module ir_source (
   input  wire logic clk, // system clock
   output logic      pin  // demodulated receiver output
);
   timeunit 1ns;
   timeprecision 1ps;
   // idles low, the same level the block assumes after reset
   initial pin = 1'b0;
   // a receiver holds its level until the next burst edge
   task automatic flip();
      pin <= ~pin;
   endtask
endmodule // ir_source

/* File: tb.sv */
/* tb: self-checking bench for ir_receive_capture.
   assumes the design files and ir_source.sv are compiled first. */
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); \
   end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ir_receive_capture_pkg::*;
   logic        clk, rst_b, tx, en, csel, rl, burst, ie, oc, rc; // inputs
   logic [1:0]  esel, dv;    // edge select, divider
   logic [7:0]  hi, lo;      // carrier bytes
   logic        rx_pin;      // receiver model output
   logic [15:0] cnt, mt;     // counter, capture
   logic        lvl, ovf, rif, irq; // flags
   logic [15:0] a;           // earlier capture
   int          num_errors, checks_done;
   ir_source src (.clk(clk), .pin(rx_pin));
   ir_receive_capture dut (.clk(clk), .rst_b(rst_b),
      .transmit_receive_select(tx), .infrared_timer_enable(en),
      .receive_edge_select(esel), .infrared_receive_pin(rx_pin),
      .counter_clock_select(csel), .input_clock_divider(dv),
      .carrier_high_byte(hi), .carrier_low_byte(lo),
      .capture_reload_bit(rl), .burst_count_enable(burst),
      .infrared_interrupt_enable(ie), .overflow_clear(oc),
      .receive_flag_clear(rc), .interval_counter(cnt),
      .modulator_time_register(mt), .captured_level_bit(lvl),
      .counter_overflow_flag(ovf), .receive_interrupt_flag(rif),
      .overflow_irq(irq));
   // 50 MHz system clock
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // wait n rising edges; every drive after time zero follows one of these
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // step to the falling edge, where registered outputs have settled
   task automatic look();
      @(negedge clk);
   endtask
   // toggle the pin n edges on, then look once the capture is registered;
   // consecutive calls space the pin edges n+1 clocks apart
   task automatic edge_at(input int n);
      tick(n);
      src.flip();
      tick(1);
      look();
   endtask
   // software clear of both sticky flags, seen at one sampling edge
   task automatic clr();
      tick(1);
      rc <= 1'b1;
      oc <= 1'b1;
      tick(1);
      rc <= 1'b0;
      oc <= 1'b0;
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog: tests need about 66000 clocks, mostly the overflow wait
   initial begin
      tick(95000);
      num_errors++;
      final_report();
   end
   initial begin
      // idle, receive mode, both edges, fastest input clock
      {rst_b, tx, en, csel, rl, burst, ie, oc, rc} <= '0;
      esel <= 2'h3;
      dv <= 2'h0;
      hi <= 8'h01;
      lo <= 8'h01;
      tick(8);
      rst_b <= 1'b1;
      // first edge out of reset: still disabled, so all quiet
      tick(1);
      look();
      `CHK({cnt, mt, lvl, ovf, rif, irq}, 36'h0)
      $display("reset done");
      // count every clock, reload on each edge
      tick(1);
      en <= 1'b1;
      csel <= 1'b1;
      rl <= 1'b1;
      // first edge only starts the counter, no capture
      edge_at(6);
      `CHK(rif, 1'b0)
      edge_at(20);
      `CHK(mt, 16'h0014)
      `CHK(lvl, 1'b0)
      `CHK(rif, 1'b1)
      `CHK(cnt, 16'h0000)
      // the clear adds two clocks to this interval
      clr();
      edge_at(30);
      `CHK(mt, 16'h0020)
      `CHK(lvl, 1'b1)
      $display("capture done");
      // divider of 2: 40 clocks give 10 counts, first interval mixed
      tick(1);
      dv <= 2'h2;
      edge_at(7);
      edge_at(40);
      `CHK(mt, 16'h000A)
      // carrier of 2+3+2 clocks: 70 clocks give 10 periods
      tick(1);
      dv <= 2'h0;
      csel <= 1'b0;
      hi <= 8'h02;
      lo <= 8'h03;
      edge_at(7);
      edge_at(70);
      `CHK(mt, 16'h000A)
      $display("clocking done");
      tick(1);
      csel <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         esel <= s[1:0];
         clr();
         repeat (2) begin
            edge_at(4);
            `CHK(rif, rx_pin ? s[0] : s[1])
            clr();
         end
      end
      $display("edge select done");
      // free running: captures differ by the 21 clock edge spacing
      esel <= 2'h3;
      rl <= 1'b0;
      edge_at(20);
      a = mt;
      edge_at(20);
      `CHK(mt - a, 16'h0015)
      for (int i = 0; i < 66000 && ovf !== 1'b1; i++)
         look();
      `CHK(ovf, 1'b1)
      `CHK(cnt, 16'h0000)
      `CHK(irq, 1'b0)
      tick(1);
      ie <= 1'b1;
      tick(1);
      look();
      `CHK(irq, 1'b1)
      tick(10);
      look();
      `CHK(ovf, 1'b1)
      clr();
      look();
      `CHK({ovf, irq}, 2'h0)
      $display("overflow done");
      // burst mode, carrier of 4+4+2 clocks
      tick(1);
      rl <= 1'b1;
      hi <= 8'h04;
      lo <= 8'h04;
      burst <= 1'b1;
      tick(1);
      look();
      `CHK(mt, 16'h0001)
      clr();
      repeat (6) edge_at(1);
      `CHK(mt, 16'h0007)
      `CHK(cnt, 16'h0000)
      `CHK(rif, 1'b0)
      // second silent period ends 20 clocks after the last edge
      tick(18);
      look();
      `CHK(rif, 1'b0)
      tick(2);
      look();
      `CHK(rif, 1'b1)
      $display("burst done");
      tick(1);
      burst <= 1'b0;
      en <= 1'b0;
      clr();
      edge_at(4);
      edge_at(4);
      `CHK(rif, 1'b0)
      tick(1);
      en <= 1'b1;
      tx <= 1'b1;
      edge_at(4);
      edge_at(4);
      `CHK(rif, 1'b0)
      // back to receive without reload: count must restart from zero
      tick(1);
      tx <= 1'b0;
      rl <= 1'b0;
      edge_at(3);
      `CHK(rif, 1'b0)
      edge_at(10);
      `CHK(mt, 16'h000A)
      $display("enable done");
      final_report();
   end
endmodule // tb
